//--- include/apig_regs.vh
// Register map, field layout and reset values for the anti-pop and input gain bank.
// Behaviour
// - Ramp speed field bits 9:8, reset zero.
// - Fourth output discharge rate bits 7:6.
// - Third output discharge rate bits 5:4.
// - Second outputs shared discharge rate bits 3:2.
// - First outputs shared discharge rate bits 1:0.
// - Left bit 15 enables left gain amplifier.
// - Left bit 14 mutes left gain amplifier.
// - Left bit 13 selects zero-cross timed update.
// - Gains wait for commit bit 8 write.
// - Left gain code bits 7:2, default 0 dB.
// - Right bit 15 enables right gain amplifier.
// - Right bit 14 mutes right gain amplifier.
// - Right bit 13 selects zero-cross timed update.
// - Right gain code bits 7:2, default 0 dB.
`ifndef APIG_REGS_VH
`define APIG_REGS_VH

// Port widths and channel count.
`define APIG_ADDR_W 8
`define APIG_DATA_W 16
`define APIG_GAIN_W 6
`define APIG_NUM_CH 2
`define APIG_SYNC_W 2

// Register addresses.
`define APIG_ADDR_ANTI_POP 8'h4e
`define APIG_ADDR_LEFT_VOL 8'h50
`define APIG_ADDR_RIGHT_VOL 8'h51
`define APIG_ADDR_STATUS 8'h52

// Anti-pop control fields.
`define APIG_RAMP_HI 9
`define APIG_RAMP_LO 8
`define APIG_DIS4_HI 7
`define APIG_DIS4_LO 6
`define APIG_DIS3_HI 5
`define APIG_DIS3_LO 4
`define APIG_DIS2_HI 3
`define APIG_DIS2_LO 2
`define APIG_DIS1_HI 1
`define APIG_DIS1_LO 0

// Input volume fields, same layout for both channels.
`define APIG_ENA_BIT 15
`define APIG_MUTE_BIT 14
`define APIG_ZC_BIT 13
`define APIG_COMMIT_BIT 8
`define APIG_GAIN_HI 7
`define APIG_GAIN_LO 2

// Gain status fields.
`define APIG_ST_R_ARMED 15
`define APIG_ST_R_GAIN_HI 13
`define APIG_ST_R_GAIN_LO 8
`define APIG_ST_L_ARMED 7
`define APIG_ST_L_GAIN_HI 5
`define APIG_ST_L_GAIN_LO 0

// Reset values.
`define APIG_RST_FIELD2 2'h0
`define APIG_RST_BIT 1'h0
`define APIG_RST_GAIN 6'h10
`define APIG_RST_DATA 16'h0000

`endif

//--- core/apig_sync2.v
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`include "apig_regs.vh"

module apig_sync2 #(
   parameter WIDTH = `APIG_SYNC_W
) (
   // Clock and reset.
   input wire ref_clk_in,
   input wire sys_rst_in,
   // Asynchronous levels in, synchronised levels out.
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // The first stage feeds only the second stage, so metastability never reaches logic.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // apig_sync2

//--- core/apig_gain_chan.v
// Active gain of one input amplifier channel with immediate or zero-cross commit.
`timescale 1ns/1ps
`include "apig_regs.vh"

module apig_gain_chan #(
   parameter GAIN_W = `APIG_GAIN_W
) (
   // Clock and reset.
   input wire ref_clk_in,
   input wire sys_rst_in,
   // Commit request and the pending gain it carries.
   input wire commit_in,
   input wire zc_mode_in,
   input wire [GAIN_W-1:0] gain_in,
   // Synchronised sign of the channel signal.
   input wire sign_in,
   // Gain the amplifier uses, and a flag for a commit waiting on a crossing.
   output reg [GAIN_W-1:0] gain_out,
   output reg armed_out
);

   reg sign_q;
   reg [GAIN_W-1:0] target_q;
   wire crossing;

   // A change of sign between two samples marks a zero crossing.
   assign crossing = sign_in ^ sign_q;

   // The target is latched at commit, so later uncommitted writes cannot leak in.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         sign_q <= `APIG_RST_BIT;
         target_q <= `APIG_RST_GAIN;
         gain_out <= `APIG_RST_GAIN;
         armed_out <= `APIG_RST_BIT;
      end else begin
         sign_q <= sign_in;
         if (commit_in && !zc_mode_in) begin
            gain_out <= gain_in;
            armed_out <= 1'b0;
         end else if (commit_in) begin
            target_q <= gain_in;
            armed_out <= 1'b1;
         end else if (armed_out && (crossing || !zc_mode_in)) begin
            gain_out <= target_q;
            armed_out <= 1'b0;
         end
      end
   end

endmodule // apig_gain_chan

//--- core/apig_antipop_gain_regs.v
// Anti-pop and input gain control register bank with its register port.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "apig_regs.vh"

module apig_antipop_gain_regs #(
   parameter ADDR_W = `APIG_ADDR_W,
   parameter GAIN_W = `APIG_GAIN_W
) (
   // Clock and reset.
   input wire ref_clk_in,
   input wire sys_rst_in,
   // Register port.
   input wire [ADDR_W-1:0] reg_addr_in,
   input wire [`APIG_DATA_W-1:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [`APIG_DATA_W-1:0] reg_rdata_out,
   // Sign of each input signal from the analog comparators.
   input wire left_zero_cross_in,
   input wire right_zero_cross_in,
   // Anti-pop settings.
   output wire [1:0] reference_midpoint_ramp_out,
   output wire [1:0] fourth_output_discharge_rate_out,
   output wire [1:0] third_output_discharge_rate_out,
   output wire [1:0] second_output_discharge_rate_out,
   output wire [1:0] first_output_discharge_rate_out,
   // Left input amplifier.
   output wire left_gain_amp_enable_out,
   output wire left_gain_amp_mute_out,
   output wire [GAIN_W-1:0] left_gain_code_out,
   output wire left_gain_pending_out,
   // Right input amplifier.
   output wire right_gain_amp_enable_out,
   output wire right_gain_amp_mute_out,
   output wire [GAIN_W-1:0] right_gain_code_out,
   output wire right_gain_pending_out
);

   localparam NUM_CH = `APIG_NUM_CH;

   // Anti-pop register state.
   reg [1:0] ramp_q;
   reg [1:0] ramp_d;
   reg [1:0] dis4_q;
   reg [1:0] dis4_d;
   reg [1:0] dis3_q;
   reg [1:0] dis3_d;
   reg [1:0] dis2_q;
   reg [1:0] dis2_d;
   reg [1:0] dis1_q;
   reg [1:0] dis1_d;

   // Read data register.
   reg [`APIG_DATA_W-1:0] rdata_q;
   reg [`APIG_DATA_W-1:0] rdata_d;

   // Address decode.
   wire hit_pop;
   wire hit_left;
   wire hit_right;
   wire wr_pop;
   wire [NUM_CH-1:0] wr_vol;
   wire commit;

   // Per-channel views, index 0 is left and index 1 is right.
   wire [NUM_CH-1:0] ena_w;
   wire [NUM_CH-1:0] mute_w;
   wire [NUM_CH-1:0] zc_w;
   wire [NUM_CH-1:0] armed_w;
   wire [NUM_CH*GAIN_W-1:0] pend_w;
   wire [NUM_CH*GAIN_W-1:0] act_w;
   wire [NUM_CH-1:0] sign_w;

   // Comparator outputs are asynchronous to this clock.
   apig_sync2 #(
      .WIDTH(NUM_CH)
   ) u_sign_sync (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({right_zero_cross_in, left_zero_cross_in}),
      .sync_out(sign_w)
   );

   // Decode each register address once.
   assign hit_pop = (reg_addr_in == `APIG_ADDR_ANTI_POP);
   assign hit_left = (reg_addr_in == `APIG_ADDR_LEFT_VOL);
   assign hit_right = (reg_addr_in == `APIG_ADDR_RIGHT_VOL);

   // Write strobes per register.
   assign wr_pop = reg_wr_in & hit_pop;
   assign wr_vol[0] = reg_wr_in & hit_left;
   assign wr_vol[1] = reg_wr_in & hit_right;

   // A one in the commit bit of either volume register releases both pending gains.
   assign commit = (|wr_vol) & reg_wdata_in[`APIG_COMMIT_BIT];

   // Next values of the anti-pop fields; a write replaces every field at once.
   always @* begin
      ramp_d = ramp_q;
      dis4_d = dis4_q;
      dis3_d = dis3_q;
      dis2_d = dis2_q;
      dis1_d = dis1_q;
      if (wr_pop) begin
         ramp_d = reg_wdata_in[`APIG_RAMP_HI:`APIG_RAMP_LO];
         dis4_d = reg_wdata_in[`APIG_DIS4_HI:`APIG_DIS4_LO];
         dis3_d = reg_wdata_in[`APIG_DIS3_HI:`APIG_DIS3_LO];
         dis2_d = reg_wdata_in[`APIG_DIS2_HI:`APIG_DIS2_LO];
         dis1_d = reg_wdata_in[`APIG_DIS1_HI:`APIG_DIS1_LO];
      end
   end

   // Anti-pop register; every field starts at zero, so no ramp and no discharge path.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ramp_q <= `APIG_RST_FIELD2;
         dis4_q <= `APIG_RST_FIELD2;
         dis3_q <= `APIG_RST_FIELD2;
         dis2_q <= `APIG_RST_FIELD2;
         dis1_q <= `APIG_RST_FIELD2;
      end else begin
         ramp_q <= ramp_d;
         dis4_q <= dis4_d;
         dis3_q <= dis3_d;
         dis2_q <= dis2_d;
         dis1_q <= dis1_d;
      end
   end

   // Codes are passed through unchanged; the analog side decodes off, fast, medium, slow.
   assign reference_midpoint_ramp_out = ramp_q;
   assign fourth_output_discharge_rate_out = dis4_q;
   assign third_output_discharge_rate_out = dis3_q;
   assign second_output_discharge_rate_out = dis2_q;
   assign first_output_discharge_rate_out = dis1_q;

   // One copy of the volume register and gain logic for each channel.
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_chan
         reg ena_q;
         reg ena_d;
         reg mute_q;
         reg mute_d;
         reg zc_q;
         reg zc_d;
         reg [GAIN_W-1:0] pend_q;
         reg [GAIN_W-1:0] pend_d;
         wire [GAIN_W-1:0] act;
         wire armed;

         // Next values; the gain code only goes to pending storage here.
         always @* begin
            ena_d = ena_q;
            mute_d = mute_q;
            zc_d = zc_q;
            pend_d = pend_q;
            if (wr_vol[ch]) begin
               ena_d = reg_wdata_in[`APIG_ENA_BIT];
               mute_d = reg_wdata_in[`APIG_MUTE_BIT];
               zc_d = reg_wdata_in[`APIG_ZC_BIT];
               pend_d = reg_wdata_in[`APIG_GAIN_HI:`APIG_GAIN_LO];
            end
         end

         // Volume register flops; the gain resets to the 0 dB code.
         always @(posedge ref_clk_in) begin
            if (sys_rst_in) begin
               ena_q <= `APIG_RST_BIT;
               mute_q <= `APIG_RST_BIT;
               zc_q <= `APIG_RST_BIT;
               pend_q <= `APIG_RST_GAIN;
            end else begin
               ena_q <= ena_d;
               mute_q <= mute_d;
               zc_q <= zc_d;
               pend_q <= pend_d;
            end
         end

         // The commit sees this cycle's write, so a write that also commits uses its own code.
         apig_gain_chan #(
            .GAIN_W(GAIN_W)
         ) u_gain (
            .ref_clk_in(ref_clk_in),
            .sys_rst_in(sys_rst_in),
            .commit_in(commit),
            .zc_mode_in(zc_d),
            .gain_in(pend_d),
            .sign_in(sign_w[ch]),
            .gain_out(act),
            .armed_out(armed)
         );

         // Gather the channel into the shared vectors.
         assign ena_w[ch] = ena_q;
         assign mute_w[ch] = mute_q;
         assign zc_w[ch] = zc_q;
         assign armed_w[ch] = armed;
         assign pend_w[ch*GAIN_W +: GAIN_W] = pend_q;
         assign act_w[ch*GAIN_W +: GAIN_W] = act;
      end
   endgenerate

   // Amplifier controls; the gain outputs carry only committed codes.
   assign left_gain_amp_enable_out = ena_w[0];
   assign left_gain_amp_mute_out = mute_w[0];
   assign left_gain_code_out = act_w[GAIN_W-1:0];
   assign left_gain_pending_out = armed_w[0];
   assign right_gain_amp_enable_out = ena_w[1];
   assign right_gain_amp_mute_out = mute_w[1];
   assign right_gain_code_out = act_w[2*GAIN_W-1:GAIN_W];
   assign right_gain_pending_out = armed_w[1];

   // Read multiplexer. The commit bit always reads zero because it only acts on write.
   // Volume registers show the pending code, so software can check it before committing.
   always @* begin
      rdata_d = `APIG_RST_DATA;
      case (reg_addr_in)
         `APIG_ADDR_ANTI_POP: begin
            rdata_d[`APIG_RAMP_HI:`APIG_RAMP_LO] = ramp_q;
            rdata_d[`APIG_DIS4_HI:`APIG_DIS4_LO] = dis4_q;
            rdata_d[`APIG_DIS3_HI:`APIG_DIS3_LO] = dis3_q;
            rdata_d[`APIG_DIS2_HI:`APIG_DIS2_LO] = dis2_q;
            rdata_d[`APIG_DIS1_HI:`APIG_DIS1_LO] = dis1_q;
         end
         `APIG_ADDR_LEFT_VOL: begin
            rdata_d[`APIG_ENA_BIT] = ena_w[0];
            rdata_d[`APIG_MUTE_BIT] = mute_w[0];
            rdata_d[`APIG_ZC_BIT] = zc_w[0];
            rdata_d[`APIG_GAIN_HI:`APIG_GAIN_LO] = pend_w[GAIN_W-1:0];
         end
         `APIG_ADDR_RIGHT_VOL: begin
            rdata_d[`APIG_ENA_BIT] = ena_w[1];
            rdata_d[`APIG_MUTE_BIT] = mute_w[1];
            rdata_d[`APIG_ZC_BIT] = zc_w[1];
            rdata_d[`APIG_GAIN_HI:`APIG_GAIN_LO] = pend_w[2*GAIN_W-1:GAIN_W];
         end
         `APIG_ADDR_STATUS: begin
            rdata_d[`APIG_ST_R_ARMED] = armed_w[1];
            rdata_d[`APIG_ST_R_GAIN_HI:`APIG_ST_R_GAIN_LO] = act_w[2*GAIN_W-1:GAIN_W];
            rdata_d[`APIG_ST_L_ARMED] = armed_w[0];
            rdata_d[`APIG_ST_L_GAIN_HI:`APIG_ST_L_GAIN_LO] = act_w[GAIN_W-1:0];
         end
         default: begin
            rdata_d = `APIG_RST_DATA;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe and are zero otherwise.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rdata_q <= `APIG_RST_DATA;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= `APIG_RST_DATA;
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule // apig_antipop_gain_regs

//--- bench/apig_properties.sv
// Checker with concurrent properties for the anti-pop and input gain register bank.
`timescale 1ns/1ps
module apig_checker #(
   parameter ADDR_W = 8,
   parameter GAIN_W = 6
) (
   // Clock, reset and register port.
   input wire ref_clk_in,
   input wire sys_rst_in,
   input wire [ADDR_W-1:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [15:0] reg_rdata_out,
   // Anti-pop settings.
   input wire [1:0] reference_midpoint_ramp_out,
   input wire [1:0] fourth_output_discharge_rate_out,
   input wire [1:0] third_output_discharge_rate_out,
   input wire [1:0] second_output_discharge_rate_out,
   input wire [1:0] first_output_discharge_rate_out,
   // Amplifier controls.
   input wire left_gain_amp_enable_out,
   input wire left_gain_amp_mute_out,
   input wire [GAIN_W-1:0] left_gain_code_out,
   input wire left_gain_pending_out,
   input wire right_gain_amp_enable_out,
   input wire right_gain_amp_mute_out,
   input wire [GAIN_W-1:0] right_gain_code_out,
   input wire right_gain_pending_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   // Decoded strobes; a commit is any volume write carrying the update bit.
   wire [9:0] ap_w = {reference_midpoint_ramp_out, fourth_output_discharge_rate_out,
      third_output_discharge_rate_out, second_output_discharge_rate_out,
      first_output_discharge_rate_out};
   wire wr_ap = reg_wr_in && (reg_addr_in == 8'h4e);
   wire wr_l = reg_wr_in && (reg_addr_in == 8'h50);
   wire wr_r = reg_wr_in && (reg_addr_in == 8'h51);
   wire commit = (wr_l || wr_r) && reg_wdata_in[8];

   // Commit steps: a volume write with update set, timed now or at a crossing.
   sequence s_now(chan);
      chan && reg_wdata_in[8] && !reg_wdata_in[13];
   endsequence
   sequence s_arm(chan);
      chan && reg_wdata_in[8] && reg_wdata_in[13];
   endsequence

   a_ap_fields_write: assert property (wr_ap |=> ap_w == $past(reg_wdata_in[9:0]))
      else $error("anti-pop fields differ from written value");
   a_ap_fields_hold: assert property (!wr_ap |=> $stable(ap_w))
      else $error("anti-pop fields changed without a write");
   a_ap_read_back: assert property (reg_rd_in && reg_addr_in == 8'h4e |=> reg_rdata_out == {6'h00, ap_w})
      else $error("anti-pop readback wrong");
   a_left_ctrl_bits: assert property (wr_l |=> {left_gain_amp_enable_out, left_gain_amp_mute_out} == $past(reg_wdata_in[15:14]))
      else $error("left enable or mute wrong");
   a_right_ctrl_bits: assert property (wr_r |=> {right_gain_amp_enable_out, right_gain_amp_mute_out} == $past(reg_wdata_in[15:14]))
      else $error("right enable or mute wrong");
   a_left_commit_now: assert property (s_now(wr_l) |=> left_gain_code_out == $past(reg_wdata_in[7:2]) && !left_gain_pending_out)
      else $error("left immediate commit wrong");
   a_right_commit_now: assert property (s_now(wr_r) |=> right_gain_code_out == $past(reg_wdata_in[7:2]))
      else $error("right immediate commit wrong");
   a_left_zc_arm: assert property (s_arm(wr_l) |=> left_gain_pending_out && $stable(left_gain_code_out))
      else $error("left zero-cross commit applied early");
   a_right_zc_arm: assert property (s_arm(wr_r) |=> right_gain_pending_out && $stable(right_gain_code_out))
      else $error("right zero-cross commit applied early");
   a_gain_waits_commit: assert property (!commit && !left_gain_pending_out && !right_gain_pending_out |=> $stable({left_gain_code_out, right_gain_code_out}))
      else $error("gain changed without commit");
   a_read_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside read");
endmodule // apig_checker

bind apig_antipop_gain_regs apig_checker #(.ADDR_W(ADDR_W), .GAIN_W(GAIN_W)) u_chk (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .reference_midpoint_ramp_out(reference_midpoint_ramp_out),
   .fourth_output_discharge_rate_out(fourth_output_discharge_rate_out),
   .third_output_discharge_rate_out(third_output_discharge_rate_out),
   .second_output_discharge_rate_out(second_output_discharge_rate_out),
   .first_output_discharge_rate_out(first_output_discharge_rate_out),
   .left_gain_amp_enable_out(left_gain_amp_enable_out),
   .left_gain_amp_mute_out(left_gain_amp_mute_out), .left_gain_code_out(left_gain_code_out),
   .left_gain_pending_out(left_gain_pending_out),
   .right_gain_amp_enable_out(right_gain_amp_enable_out),
   .right_gain_amp_mute_out(right_gain_amp_mute_out), .right_gain_code_out(right_gain_code_out),
   .right_gain_pending_out(right_gain_pending_out));

//--- bench/test_antipop_input_gain_regs.sv
// Self-checking bench for the anti-pop and input gain register bank.
`timescale 1ns/1ps
module test_antipop_input_gain_regs;
   typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] r; logic [15:0] o;} apig_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic zl = 1'b0;
   logic zr = 1'b0;
   wire [15:0] rdata;
   wire [1:0] ramp, d4, d3, d2, d1;
   wire len, lmute, lpend, ren, rmute, rpend;
   wire [5:0] lcode, rcode;
   int num_errors = 0;
   int n_tests = 0;
   // Rows: address, write data, expected readback, expected settings.
   apig_row_t rows [8] = '{
      '{8'h4e, 16'h0155, 16'h0155, 16'h0155}, '{8'h4e, 16'hfeaa, 16'h02aa, 16'h02aa},
      '{8'h4e, 16'h03ff, 16'h03ff, 16'h03ff}, '{8'h4e, 16'h0000, 16'h0000, 16'h0000},
      '{8'h50, 16'h80fc, 16'h80fc, 16'h8000}, '{8'h50, 16'h4000, 16'h4000, 16'h4000},
      '{8'h51, 16'hc004, 16'hc004, 16'hc000}, '{8'h51, 16'h20f0, 16'h20f0, 16'h0000}};

   apig_antipop_gain_regs u_dut (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .left_zero_cross_in(zl), .right_zero_cross_in(zr), .reference_midpoint_ramp_out(ramp),
      .fourth_output_discharge_rate_out(d4), .third_output_discharge_rate_out(d3),
      .second_output_discharge_rate_out(d2), .first_output_discharge_rate_out(d1),
      .left_gain_amp_enable_out(len), .left_gain_amp_mute_out(lmute),
      .left_gain_code_out(lcode), .left_gain_pending_out(lpend),
      .right_gain_amp_enable_out(ren), .right_gain_amp_mute_out(rmute),
      .right_gain_code_out(rcode), .right_gain_pending_out(rpend));

   // The clock toggles every half period of 5 ns.
   always #5 clk = ~clk;

   // Settings that belong to one register, packed as its readback would place them.
   function automatic logic [15:0] obs(input logic [7:0] a);
      if (a == 8'h4e) return {6'h00, ramp, d4, d3, d2, d1};
      if (a == 8'h50) return {len, lmute, 14'h0000};
      return {ren, rmute, 14'h0000};
   endfunction

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Each access holds its strobe for exactly one cycle; #1 lets the edge's updates land.
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Crossings are bounded waits so a stuck commit shows up as a mismatch, not a hang.
   task wait_idle();
      for (int n = 0; n < 8 && (lpend | rpend) !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
   endtask

   task test_done();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs under a hundred cycles, so 5000 means a hang.
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      test_done();
   end

   // Main sequence.
   initial begin
      logic [15:0] v;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(obs(8'h4e), 16'h0000);
      chk({len, lmute, ren, rmute, lpend, rpend}, 16'h0000);
      chk({lcode, rcode}, 16'h0410);
      rd_reg(8'h50, v);
      chk(v, 16'h0040);
      $display("reset test done");
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].w);
         chk(obs(rows[i].a), rows[i].o);
         rd_reg(rows[i].a, v);
         chk(v, rows[i].r);
      end
      chk({lcode, rcode}, 16'h0410);
      $display("register rows test done");
      wr_reg(8'h50, 16'h0004);
      chk(lcode, 16'h0010);
      wr_reg(8'h51, 16'h0108);
      chk({lcode, rcode}, 16'h0042);
      wr_reg(8'h50, 16'h00fc);
      wr_reg(8'h51, 16'h0100);
      chk({lcode, rcode}, 16'h0fc0);
      $display("commit test done");
      wr_reg(8'h50, 16'h2114);
      repeat (3) @(posedge clk);
      #1;
      chk({lpend, lcode}, 16'h007f);
      @(posedge clk) zl <= 1'b1;
      wait_idle();
      chk({lpend, lcode}, 16'h0005);
      wr_reg(8'h51, 16'h2120);
      chk({rpend, rcode}, 16'h0040);
      @(posedge clk);
      zr <= 1'b1;
      zl <= 1'b0;
      wait_idle();
      chk({lpend, lcode, rpend, rcode}, 16'h0288);
      $display("zero cross test done");
      wr_reg(8'h60, 16'hffff);
      wr_reg(8'h52, 16'hffff);
      rd_reg(8'h60, v);
      chk(v, 16'h0000);
      chk(obs(8'h4e), 16'h0000);
      // Status shows both committed codes and no waiting commit.
      rd_reg(8'h52, v);
      chk(v, 16'h0805);
      $display("unmapped test done");
      // A reset in mid-run must bring the gains back to the 0 dB code.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({lpend, lcode, rpend, rcode}, 16'h0810);
      chk(obs(8'h50), 16'h0000);
      $display("mid-run reset test done");
      test_done();
   end
endmodule // test_antipop_input_gain_regs
